/* card_event_pkg.sv */
// constants for the card status-change flag block
// assumes one 10 MHz clock and a byte-wide register port
// Behaviour
// [RULE1] disabled source flag always reads zero
// [RULE2] enabled active flag raises host interrupt
// [RULE3] flags cleared by read or write-one
// [RULE4] global control bit 2 picks clear mode
// [RULE5] flag bits 7 to 4 read zero
// [RULE6] bit 3 set on card-detect change
// [RULE7] memory card: bit 2 on ready rise
// [RULE8] io card: bit 2 reads zero
// [RULE9] memory card: bit 1 on battery low
// [RULE10] io card: bit 1 reads zero
// [RULE11] memory card: bit 0 shows battery dead
// [RULE12] io card with ring: bit 0 ring
// [RULE13] flags at offset 804h, reset zero
// [RULE14] config at offset 805h, rw, reset zero
// [RULE15] config bit 3 enables detect change
// [RULE16] config bit 2 enables ready rise
// [RULE17] card kind bit selects memory or io
// [RULE18] control bit 7 enables ring function
// [RULE19] interrupt held while enabled flag set
package card_event_pkg;

  // ***************************************
  // register map
  // ***************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] GEN_CTRL_ADDR = 12'h803;
  localparam logic [ADDR_W-1:0] FLAGS_ADDR = 12'h804;
  localparam logic [ADDR_W-1:0] CONFIG_ADDR = 12'h805;
  localparam logic [ADDR_W-1:0] GLOBAL_ADDR = 12'h81e;
  localparam logic [DATA_W-1:0] GEN_CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h00;
  localparam logic CLEAR_MODE_RESET = 1'h0;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

  // ***************************************
  // field positions
  // ***************************************
  localparam int FLAG_DETECT = 3;
  localparam int FLAG_READY = 2;
  localparam int FLAG_BATTERY = 1;
  localparam int FLAG_DEAD_RING = 0;
  localparam int CFG_DETECT_EN = 3;
  localparam int CFG_READY_EN = 2;
  localparam int CFG_BATTERY_EN = 1;
  localparam int CFG_DEAD_EN = 0;
  localparam int GEN_RING_EN = 7;
  localparam int GEN_CARD_KIND = 5;
  localparam int GLOBAL_CLEAR_MODE = 2;
  localparam logic [2:0] FLAGS_RESET = 3'h0;

  // ***************************************
  // synchroniser lanes and idle levels
  // ***************************************
  localparam int SYNC_W = 6;
  localparam int LANE_DETECT_FIRST = 0;
  localparam int LANE_DETECT_SECOND = 1;
  localparam int LANE_READY = 2;
  localparam int LANE_BATTERY_LOW = 3;
  localparam int LANE_STATUS = 4;
  localparam int LANE_RING = 5;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 6'h3b;

endpackage

/* signal_sync2.sv */
// two-flop synchroniser for card pins
// assumes asynchronous pins and one destination clock
`timescale 1ns/1ps
module signal_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= IDLE;
      o_sync <= IDLE;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

/* card_event_flags.sv */
// card status-change flag and interrupt request logic
// assumes card pins asynchronous, register port on i_clock
`timescale 1ns/1ps
module card_event_flags (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // register port
  input wire logic [card_event_pkg::ADDR_W-1:0] i_address,
  input wire logic [card_event_pkg::DATA_W-1:0] i_write_data,
  input wire logic i_write_strobe,
  input wire logic i_read_strobe,
  output logic [card_event_pkg::DATA_W-1:0] o_read_data,
  // card pins
  input wire logic i_card_detect_first_n,
  input wire logic i_card_detect_second_n,
  input wire logic i_ready,
  input wire logic i_battery_low_n,
  input wire logic i_card_status_input_n,
  input wire logic i_ring_input_n,
  // host interrupt request
  output logic o_card_event_irq
);

  // ***************************************
  // state
  // ***************************************
  typedef struct packed {
    logic armed_q;
    logic [card_event_pkg::SYNC_W-1:0] prev_q;
    logic [3:1] flags_q;
    logic [card_event_pkg::DATA_W-1:0] gen_ctrl_q;
    logic [card_event_pkg::DATA_W-1:0] config_q;
    logic clear_mode_q;
    logic [card_event_pkg::DATA_W-1:0] read_data_q;
    logic irq_q;
  } state_s;

  state_s q;
  state_s d;
  logic [card_event_pkg::SYNC_W-1:0] pins;
  logic [card_event_pkg::SYNC_W-1:0] sync;
  logic memory_card;
  logic detect_set;
  logic ready_set;
  logic battery_set;
  logic level_bit;
  logic flags_read;
  logic flags_write;
  logic [3:1] set_vec;
  logic [3:1] clear_vec;
  logic [3:1] keep_vec;
  logic [card_event_pkg::DATA_W-1:0] visible;

  // ***************************************
  // pin synchronisers
  // ***************************************
  assign pins = {i_ring_input_n, i_card_status_input_n, i_battery_low_n,
                 i_ready, i_card_detect_second_n, i_card_detect_first_n};

  signal_sync2 #(
    .WIDTH(card_event_pkg::SYNC_W),
    .IDLE(card_event_pkg::SYNC_IDLE)
  ) u_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_async(pins),
    .o_sync(sync)
  );

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    d = q;
    d.armed_q = 1'b1;
    d.prev_q = sync;
    memory_card = ~q.gen_ctrl_q[card_event_pkg::GEN_CARD_KIND]; // RULE17
    // sticky event sources
    detect_set = q.armed_q && q.config_q[card_event_pkg::CFG_DETECT_EN] && // RULE15
                 ((sync[card_event_pkg::LANE_DETECT_FIRST] ^ q.prev_q[card_event_pkg::LANE_DETECT_FIRST]) ||
                  (sync[card_event_pkg::LANE_DETECT_SECOND] ^ q.prev_q[card_event_pkg::LANE_DETECT_SECOND])); // RULE6
    ready_set = q.armed_q && memory_card && q.config_q[card_event_pkg::CFG_READY_EN] && // RULE16
                sync[card_event_pkg::LANE_READY] && !q.prev_q[card_event_pkg::LANE_READY]; // RULE7
    battery_set = q.armed_q && memory_card && q.config_q[card_event_pkg::CFG_BATTERY_EN] &&
                  !sync[card_event_pkg::LANE_BATTERY_LOW] && q.prev_q[card_event_pkg::LANE_BATTERY_LOW]; // RULE9
    // bit 0 is a live level
    if (!q.config_q[card_event_pkg::CFG_DEAD_EN]) begin
      level_bit = 1'b0; // RULE1
    end else if (memory_card) begin
      level_bit = ~sync[card_event_pkg::LANE_STATUS]; // RULE11
    end else if (q.gen_ctrl_q[card_event_pkg::GEN_RING_EN]) begin
      level_bit = ~sync[card_event_pkg::LANE_RING]; // RULE12 RULE18
    end else begin
      level_bit = ~sync[card_event_pkg::LANE_STATUS];
    end
    // visible flag byte, reserved bits zero
    visible = card_event_pkg::READ_IDLE; // RULE5
    visible[card_event_pkg::FLAG_DETECT] = q.flags_q[card_event_pkg::FLAG_DETECT] &
                                           q.config_q[card_event_pkg::CFG_DETECT_EN]; // RULE1
    visible[card_event_pkg::FLAG_READY] = q.flags_q[card_event_pkg::FLAG_READY] & memory_card &
                                          q.config_q[card_event_pkg::CFG_READY_EN]; // RULE8
    visible[card_event_pkg::FLAG_BATTERY] = q.flags_q[card_event_pkg::FLAG_BATTERY] & memory_card &
                                            q.config_q[card_event_pkg::CFG_BATTERY_EN]; // RULE10
    visible[card_event_pkg::FLAG_DEAD_RING] = level_bit;
    // clearing: read clears when mode 0, write-one when mode 1
    flags_read = i_read_strobe && (i_address == card_event_pkg::FLAGS_ADDR);
    flags_write = i_write_strobe && (i_address == card_event_pkg::FLAGS_ADDR);
    clear_vec = 3'h0;
    if (flags_read && !q.clear_mode_q) begin
      clear_vec = visible[3:1]; // RULE3 RULE4
    end else if (flags_write && q.clear_mode_q) begin
      clear_vec = i_write_data[3:1]; // RULE3 RULE4
    end
    set_vec = {detect_set, ready_set, battery_set};
    // a disabled source drops its stored flag; an io card also drops the ready and battery flags
    keep_vec = {q.config_q[card_event_pkg::CFG_DETECT_EN],
                memory_card & q.config_q[card_event_pkg::CFG_READY_EN],
                memory_card & q.config_q[card_event_pkg::CFG_BATTERY_EN]};
    d.flags_q = ((q.flags_q & ~clear_vec) | set_vec) & keep_vec; // set wins over clear
    // register writes
    if (i_write_strobe) begin
      if (i_address == card_event_pkg::GEN_CTRL_ADDR) begin
        d.gen_ctrl_q = i_write_data;
      end else if (i_address == card_event_pkg::CONFIG_ADDR) begin
        d.config_q = i_write_data; // RULE14
      end else if (i_address == card_event_pkg::GLOBAL_ADDR) begin
        d.clear_mode_q = i_write_data[card_event_pkg::GLOBAL_CLEAR_MODE];
      end
    end
    // register reads, data in the following cycle only
    d.read_data_q = card_event_pkg::READ_IDLE;
    if (i_read_strobe) begin
      if (i_address == card_event_pkg::GEN_CTRL_ADDR) begin
        d.read_data_q = q.gen_ctrl_q;
      end else if (i_address == card_event_pkg::FLAGS_ADDR) begin
        d.read_data_q = visible; // RULE13
      end else if (i_address == card_event_pkg::CONFIG_ADDR) begin
        d.read_data_q = q.config_q; // RULE14
      end else if (i_address == card_event_pkg::GLOBAL_ADDR) begin
        d.read_data_q[card_event_pkg::GLOBAL_CLEAR_MODE] = q.clear_mode_q;
      end
    end
    // interrupt request follows the enabled flags
    d.irq_q = (|d.flags_q) | level_bit; // RULE2 RULE19
  end

  // ***************************************
  // state register
  // ***************************************
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      q.armed_q <= 1'b0;
      q.prev_q <= card_event_pkg::SYNC_IDLE;
      q.flags_q <= card_event_pkg::FLAGS_RESET; // RULE13
      q.gen_ctrl_q <= card_event_pkg::GEN_CTRL_RESET;
      q.config_q <= card_event_pkg::CONFIG_RESET; // RULE14
      q.clear_mode_q <= card_event_pkg::CLEAR_MODE_RESET;
      q.read_data_q <= card_event_pkg::READ_IDLE;
      q.irq_q <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign o_read_data = q.read_data_q;
  assign o_card_event_irq = q.irq_q;

  // ***************************************
  // assertions
  // ***************************************
  reserved_bits_zero_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE5
    (i_read_strobe && i_address == card_event_pkg::FLAGS_ADDR) |=> (o_read_data[7:4] == 4'h0))
    else $error("reserved flag bits not zero");

  read_data_idle_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !i_read_strobe |=> (o_read_data == 8'h00))
    else $error("read data outside read cycle");

  disabled_detect_zero_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE1
    (i_read_strobe && i_address == card_event_pkg::FLAGS_ADDR &&
     !q.config_q[card_event_pkg::CFG_DETECT_EN]) |=> !o_read_data[card_event_pkg::FLAG_DETECT])
    else $error("disabled detect flag read as one");

  io_card_zero_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE8
    (i_read_strobe && i_address == card_event_pkg::FLAGS_ADDR &&
     q.gen_ctrl_q[card_event_pkg::GEN_CARD_KIND]) |=> (o_read_data[2:1] == 2'h0))
    else $error("io card shows ready or battery flag");

  read_clear_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE3
    (i_read_strobe && i_address == card_event_pkg::FLAGS_ADDR && !q.clear_mode_q && !detect_set)
    |=> !q.flags_q[card_event_pkg::FLAG_DETECT])
    else $error("read did not clear detect flag");

  write_mode_keep_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE4
    (i_read_strobe && i_address == card_event_pkg::FLAGS_ADDR && q.clear_mode_q &&
     q.flags_q[card_event_pkg::FLAG_DETECT] && q.config_q[card_event_pkg::CFG_DETECT_EN] && !i_write_strobe)
    |=> q.flags_q[card_event_pkg::FLAG_DETECT])
    else $error("read cleared flag in write-one mode");

  irq_held_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE19
    (q.flags_q[card_event_pkg::FLAG_DETECT] && q.config_q[card_event_pkg::CFG_DETECT_EN] &&
     !i_read_strobe && !i_write_strobe) |=> o_card_event_irq)
    else $error("interrupt dropped with flag set");

  irq_quiet_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE2
    o_card_event_irq |-> $past(|d.flags_q | level_bit) && (q.flags_q != 3'h0 || $past(level_bit)))
    else $error("interrupt without active flag");

  ready_rise_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE7
    ready_set |=> q.flags_q[card_event_pkg::FLAG_READY])
    else $error("ready rise not latched");

  detect_change_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE6
    ($changed(sync[card_event_pkg::LANE_DETECT_FIRST]) && q.armed_q &&
     q.config_q[card_event_pkg::CFG_DETECT_EN] && $stable(q.config_q))
    |=> q.flags_q[card_event_pkg::FLAG_DETECT])
    else $error("detect change not latched");

  config_write_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE14
    (i_write_strobe && i_address == card_event_pkg::CONFIG_ADDR) |=> (q.config_q == $past(i_write_data)))
    else $error("config write lost");

endmodule

/* card_pins_model.sv */
// behavioural card in the socket, driving its status pins
// assumes the bench commands card state; pins change after rising edges
`timescale 1ns/1ps
module card_pins_model (
  // clock
  input wire logic i_clock,
  // card state commands
  input wire logic i_inserted,
  input wire logic i_ready,
  input wire logic i_battery_low,
  input wire logic i_status,
  input wire logic i_ring,
  // card pins
  output logic o_card_detect_first_n,
  output logic o_card_detect_second_n,
  output logic o_ready,
  output logic o_battery_low_n,
  output logic o_card_status_input_n,
  output logic o_ring_input_n
);
  // ***************************************
  // pin drivers
  // ***************************************
  initial begin
    o_card_detect_first_n = 1'b1;
    o_card_detect_second_n = 1'b1;
    o_ready = 1'b0;
    o_battery_low_n = 1'b1;
    o_card_status_input_n = 1'b1;
    o_ring_input_n = 1'b1;
  end
  // second detect pin lags the first by one cycle
  always @(posedge i_clock) begin
    o_card_detect_first_n <= ~i_inserted;
    o_card_detect_second_n <= o_card_detect_first_n;
    o_ready <= i_ready;
    o_battery_low_n <= ~i_battery_low;
    o_card_status_input_n <= ~i_status;
    o_ring_input_n <= ~i_ring;
  end
endmodule

/* card_event_flags_test.sv */
// self-checking bench for the card status-change flag block
// assumes a card pin model on the far side and the byte register port
`timescale 1ns/1ps
module card_event_flags_test;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic [card_event_pkg::ADDR_W-1:0] i_address = '0;
  logic [card_event_pkg::DATA_W-1:0] i_write_data = '0;
  logic i_write_strobe = 1'b0;
  logic i_read_strobe = 1'b0;
  logic [card_event_pkg::DATA_W-1:0] o_read_data;
  logic o_card_event_irq;
  logic cd1_n, cd2_n, rdy, bat_n, sts_n, ring_n;
  logic c_ins = 1'b0, c_rdy = 1'b0, c_bat = 1'b0, c_sts = 1'b0, c_ring = 1'b0;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  integer seed = 32'hb2f6;
  logic [7:0] d;
  // ***************************************
  // design and card
  // ***************************************
  card_event_flags u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_address(i_address),
    .i_write_data(i_write_data), .i_write_strobe(i_write_strobe), .i_read_strobe(i_read_strobe),
    .o_read_data(o_read_data), .i_card_detect_first_n(cd1_n), .i_card_detect_second_n(cd2_n),
    .i_ready(rdy), .i_battery_low_n(bat_n), .i_card_status_input_n(sts_n),
    .i_ring_input_n(ring_n), .o_card_event_irq(o_card_event_irq));
  card_pins_model u_card (.i_clock(i_clock), .i_inserted(c_ins), .i_ready(c_rdy),
    .i_battery_low(c_bat), .i_status(c_sts), .i_ring(c_ring), .o_card_detect_first_n(cd1_n),
    .o_card_detect_second_n(cd2_n), .o_ready(rdy), .o_battery_low_n(bat_n),
    .o_card_status_input_n(sts_n), .o_ring_input_n(ring_n));
  // ***************************************
  // clock, timeout, tasks
  // ***************************************
  initial begin
    forever #50 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      results();
    end
  end
  task results();
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_address <= a;
    i_write_data <= v;
    i_write_strobe <= 1'b1;
    @(posedge i_clock);
    i_write_strobe <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_address <= a;
    i_read_strobe <= 1'b1;
    @(posedge i_clock);
    i_read_strobe <= 1'b0;
    #1;
    check_count = check_count + 1;
    if (o_read_data !== e) begin
      n_errors = n_errors + 1;
      $display("mismatch %0t read %h got %h want %h", $time, a, o_read_data, e);
    end
  endtask
  task chk_irq(input logic e);
    #1;
    check_count = check_count + 1;
    if (o_card_event_irq !== e) begin
      n_errors = n_errors + 1;
      $display("mismatch %0t irq got %b want %b", $time, o_card_event_irq, e);
    end
  endtask
  // ***************************************
  // main sequence
  // ***************************************
  initial begin
    wt(8);
    i_resetn <= 1'b1;
    rd(12'h803, 8'h00);
    rd(12'h804, 8'h00);
    rd(12'h805, 8'h00);
    rd(12'h81e, 8'h00);
    d = $random(seed);
    wr({1'b0, d, 3'h0}, 8'hff);
    rd({1'b0, d, 3'h0}, 8'h00);
    rd(12'h805, 8'h00);
    repeat (4) begin
      d = $random(seed);
      wr(12'h805, d);
      rd(12'h805, d);
    end
    wr(12'h805, 8'h0f);
    c_ins <= 1'b1;
    wt(8);
    chk_irq(1'b1);
    rd(12'h804, 8'h08);
    wt(3);
    chk_irq(1'b0);
    rd(12'h804, 8'h00);
    c_rdy <= 1'b1;
    wt(8);
    rd(12'h804, 8'h04);
    c_bat <= 1'b1;
    wt(8);
    rd(12'h804, 8'h02);
    c_sts <= 1'b1;
    wt(8);
    rd(12'h804, 8'h01);
    rd(12'h804, 8'h01);
    chk_irq(1'b1);
    c_sts <= 1'b0;
    wt(8);
    rd(12'h804, 8'h00);
    chk_irq(1'b0);
    wr(12'h805, 8'h00);
    c_rdy <= 1'b0;
    wt(4);
    c_rdy <= 1'b1;
    c_ins <= 1'b0;
    c_sts <= 1'b1;
    wt(8);
    rd(12'h804, 8'h00);
    chk_irq(1'b0);
    c_sts <= 1'b0;
    wr(12'h81e, 8'h04);
    rd(12'h81e, 8'h04);
    wr(12'h805, 8'h0f);
    c_ins <= 1'b1;
    wt(8);
    rd(12'h804, 8'h08);
    rd(12'h804, 8'h08);
    wr(12'h804, 8'h08);
    wt(2);
    rd(12'h804, 8'h00);
    chk_irq(1'b0);
    wr(12'h81e, 8'h00);
    wr(12'h803, 8'h20);
    c_rdy <= 1'b0;
    c_bat <= 1'b0;
    wt(4);
    c_rdy <= 1'b1;
    c_bat <= 1'b1;
    wt(8);
    rd(12'h804, 8'h00);
    c_sts <= 1'b1;
    wt(8);
    rd(12'h804, 8'h01);
    wr(12'h803, 8'ha0);
    wt(2);
    rd(12'h804, 8'h00);
    c_ring <= 1'b1;
    wt(8);
    rd(12'h804, 8'h01);
    results();
  end
endmodule
